// ### tb/bert_counters_error_insertion_bench.sv
`timescale 1ns/100ps
`default_nettype none

module bert_counters_error_insertion_bench;
	logic                  clk = 1'b0;
	logic                  arst_n;
	logic [7:0]            addr = 8'h00;
	logic [7:0]            wdata = 8'h00;
	logic                  hwr = 1'b0;
	logic                  hrd = 1'b0;
	logic                  go = 1'b0;
	logic [7:0]            rdata;
	bert_pkg::bert_slot_t  slot;
	bert_pkg::bert_rxbit_t line_rx;
	bert_pkg::bert_rxbit_t sys_tx;
	bert_pkg::bert_txbit_t line_tx;
	bert_pkg::bert_txbit_t sys_rx;
	logic [7:0]            ic = 8'h00; // Shadow of interface control
	logic                  rd_d = 1'b0;
	logic                  acc = 1'b0;
	logic [15:0]           q[$];       // Expected read as {lowest, highest}
	logic [15:0]           e;
	logic [7:0]            lim;
	int                    n_mismatch = 0;
	int                    cmp_count = 0;
	int                    n_slot = 0;
	int                    nv = 0;     // Tester bits on the selected path
	logic [7:0]            mask_a [6] = '{8'hE0, 8'hEA, 8'hEB, 8'hEC,
		8'hED, 8'hE5};
	logic [7:0]            mask_v [6] = '{8'h1E, 8'h5B, 8'h9F, 8'hFF,
		8'h03, 8'h00};

	always #4 clk = ~clk;

	bert_top DUT (
		.I_REF_CLK      (clk),
		.I_ARST_N       (arst_n),
		.I_ADDR         (addr),
		.I_WDATA        (wdata),
		.I_WR           (hwr),
		.I_RD           (hrd),
		.O_RDATA        (rdata),
		.I_LINE_TX_SLOT (slot),
		.I_SYS_RX_SLOT  (slot),
		.I_LINE_RX      (line_rx),
		.I_SYS_TX       (sys_tx),
		.O_LINE_TX      (line_tx),
		.O_SYS_RX       (sys_rx)
	);

	bert_framer_model far_end (
		.i_clk     (clk),
		.i_arst_n  (arst_n),
		.i_go      (go),
		.i_line_tx (line_tx),
		.i_sys_rx  (sys_rx),
		.o_slot    (slot),
		.o_line_rx (line_rx),
		.o_sys_tx  (sys_tx)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// One idle cycle between accesses keeps each strobe a clean pulse
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr  = a;
		wdata = d;
		hwr   = 1'b1;
		@(negedge clk);
		hwr   = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] lo,
		input logic [7:0] hi);
		@(negedge clk);
		addr = a;
		hrd  = 1'b1;
		q.push_back({lo, hi});
		@(negedge clk);
		hrd  = 1'b0;
	endtask : reg_rd

	// Configuration only changes while no slots are offered
	task automatic set_ic(input logic [7:0] v);
		reg_wr(8'hEA, v);
		ic = v;
	endtask : set_ic

	task automatic latch();
		reg_wr(8'hE0, 8'h08);
		reg_wr(8'hE0, 8'h0A);
	endtask : latch

	task automatic run(input int n);
		int t;
		t = n_slot + n;
		@(negedge clk);
		go = 1'b1;
		for (int i = 0; i < 8 * n && n_slot < t; i++)
			@(negedge clk);
		go = 1'b0;
		repeat (6) @(negedge clk);
	endtask : run

	// Self-synchronising check: each inserted error shows as three
	task automatic measure(input int n, input int per, input int fixed);
		logic [31:0] b;
		logic [23:0] lo;
		logic [23:0] hi;
		int          fl;
		latch();
		nv = 0;
		run(n);
		latch();
		b  = nv;
		fl = (per == 0) ? 0 : nv / per;
		lo = (per == 0) ? 24'(fixed) : 24'((3 * fl > 2) ? 3 * fl - 2 : 0);
		hi = (per == 0) ? 24'(fixed) : 24'(3 * fl + 5);
		for (int i = 0; i < 4; i++)
			reg_rd(8'hE3 + 8'(i), b[8*i +: 8], b[8*i +: 8]);
		for (int i = 0; i < 3; i++)
			reg_rd(8'hE7 + 8'(i), lo[8*i +: 8], hi[8*i +: 8]);
	endtask : measure

	// Note what the design took at this edge
	always @(posedge clk) begin
		rd_d   <= hrd;
		acc    <= slot.stb & ic[0] & (~slot.fbit | ic[3]);
		n_slot <= n_slot + int'(slot.stb);
	end

	// Compare at the falling edge, once outputs have settled
	always @(negedge clk) begin
		if (arst_n) begin
			chk(line_tx.valid, acc & ~ic[1]);
			chk(sys_rx.valid, acc & ic[1]);
			if (ic[1] ? sys_rx.valid : line_tx.valid)
				nv++;
			if (rd_d) begin
				e   = q.pop_front();
				lim = (rdata >= e[15:8] && rdata <= e[7:0]) ? rdata : e[15:8];
				chk(rdata, lim);
			end
		end
	end

	initial begin
		arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		// Reset values, including the unmapped places E1, E2 and F0
		for (int a = 32'h000000E0; a <= 32'h000000F0; a++)
			reg_rd(8'(a), 8'h00, 8'h00);
		foreach (mask_a[i]) begin
			reg_wr(mask_a[i], 8'hFF);
			reg_rd(mask_a[i], mask_v[i], mask_v[i]);
		end
		reg_wr(8'hEB, 8'h00);
		// 55-octet pattern with a byte-align toggle, then back to PRBS
		reg_wr(8'hE0, 8'h18);
		set_ic(8'h01);
		set_ic(8'h11);
		run(64);
		reg_wr(8'hE0, 8'h08);
		set_ic(8'h01);
		run(64);
		measure(300, 0, 0);
		set_ic(8'h03);
		measure(300, 0, 0);
		set_ic(8'h4B);
		measure(300, 0, 0);
		set_ic(8'h00);
		measure(100, 0, 0);
		set_ic(8'h01);
		// Constant mode, rate codes 0 to 2; the quota is ignored
		for (int c = 0; c < 3; c++) begin
			reg_wr(8'hEB, 8'h10 | 8'(c));
			measure(200, (c == 0) ? 0 : 8 << c, 0);
		end
		// Counted mode with a quota that uses the high bits
		reg_wr(8'hEB, 8'h01);
		run(40);
		reg_wr(8'hEC, 8'h03);
		reg_wr(8'hED, 8'h01);
		reg_wr(8'hEB, 8'h81);
		reg_rd(8'hEE, 8'h03, 8'h03);
		reg_rd(8'hEF, 8'h01, 8'h01);
		measure(4400, 0, 777);
		reg_rd(8'hEE, 8'h00, 8'h00);
		reg_rd(8'hEF, 8'h00, 8'h00);
		wrap_up();
	end

	// Cut a hang short well past the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
endmodule : bert_counters_error_insertion_bench
`default_nettype wire

// ### tb/bert_framer_model.sv
`timescale 1ns/100ps
`default_nettype none

// Framer stand-in: offers bit slots with random gaps and loops bits back
module bert_framer_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire logic                  i_go,
	input  wire bert_pkg::bert_txbit_t i_line_tx,
	input  wire bert_pkg::bert_txbit_t i_sys_rx,
	output bert_pkg::bert_slot_t       o_slot,
	output bert_pkg::bert_rxbit_t      o_line_rx,
	output bert_pkg::bert_rxbit_t      o_sys_tx
);
	integer     seed = 87;
	logic [7:0] pos;
	logic [1:0] gap;
	logic       fb_d;

	// Framed F-bit slots return framer data that the tester must skip
	function automatic bert_pkg::bert_rxbit_t echo(
		bert_pkg::bert_txbit_t t, logic f, logic [1:0] r);
		echo.stb  = t.valid | f;
		echo.fbit = echo.stb ? f : r[0];
		echo.data = t.valid ? t.data : r[1];
	endfunction : echo

	// Idle qualifiers keep changing so a stale value is never mistaken
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pos       <= 8'h00;
			gap       <= 2'h0;
			fb_d      <= 1'b0;
			o_slot    <= '0;
			o_line_rx <= '0;
			o_sys_tx  <= '0;
		end else begin
			fb_d      <= o_slot.stb & o_slot.fbit;
			o_line_rx <= echo(i_line_tx, fb_d, 2'($random(seed)));
			o_sys_tx  <= echo(i_sys_rx, fb_d, 2'($random(seed)));
			if (i_go && gap == 2'h0) begin
				o_slot <= {1'b1, pos == 8'h00, pos[2:0] == 3'h1};
				pos    <= (pos == 8'hC0) ? 8'h00 : pos + 8'h01;
				gap    <= 2'($random(seed));
			end else begin
				o_slot <= {1'b0, 2'($random(seed))};
				gap    <= gap - {1'b0, gap != 2'h0};
			end
		end
	end
endmodule : bert_framer_model
`default_nettype wire

// ### verilog/bert_patgen.sv
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.svh"

// Pattern engine: PRBS 2^15-1 or a 55-octet repeating pattern
module bert_patgen (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	input  wire logic i_stb,
	input  wire logic i_realign,
	input  wire logic i_byte_start,
	input  wire logic i_daly,
	input  wire logic i_selfsync,
	input  wire logic i_in_bit,
	output logic      o_bit
);

	bert_pkg::bert_gen_state_t st;
	bert_pkg::bert_gen_state_t next_st;
	logic                      fb;

	// Feedback of x^15 + x^14 + 1; octet content comes from a PRBS7 run
	assign fb = st.lfsr[14] ^ st.lfsr[13];
	assign o_bit = i_daly ? st.prbs7[6] : fb;

	// Advance one bit per strobe; a byte start forces bit 0 of an octet
	always_comb begin
		next_st = st;
		if (i_realign) begin
			next_st.bitno = 3'h0;
			next_st.octet = 6'h00;
			next_st.prbs7 = `BERT_PRBS7_SEED;
		end else if (i_stb) begin
			// Self-sync loads received bits so the checker locks quickly
			next_st.lfsr = {st.lfsr[13:0], i_selfsync ? i_in_bit : fb};
			next_st.prbs7 = {st.prbs7[5:0], st.prbs7[6] ^ st.prbs7[5]};
			next_st.bitno = (i_byte_start ? 3'h0 : st.bitno) + 3'h1;
			if ((i_byte_start ? 3'h0 : st.bitno) == 3'h7) begin
				next_st.bitno = 3'h0;
				if (st.octet == `BERT_DALY_LAST) begin
					next_st.octet = 6'h00;
					next_st.prbs7 = `BERT_PRBS7_SEED;
				end else begin
					next_st.octet = st.octet + 6'h01;
				end
			end
		end
	end

	// A realign always restarts the octet and bit position
	AST_REALIGN: assert property (
		@(posedge i_clk) disable iff (!i_arst_n)
		i_realign |=> st.bitno == 3'h0 && st.octet == 6'h00)
		else $error("pattern not realigned");

	// State register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st <= '{lfsr: `BERT_PRBS15_SEED, prbs7: `BERT_PRBS7_SEED,
				octet: 6'h00, bitno: 3'h0};
		end else begin
			st <= next_st;
		end
	end

endmodule : bert_patgen
`default_nettype wire

// ### verilog/bert_pkg.sv
package bert_pkg;

	// Bit slot offered by a formatter to the generator
	typedef struct packed {
		logic stb;
		logic fbit;
		logic byte_start;
	} bert_slot_t;

	// Received bit offered to the checker
	typedef struct packed {
		logic stb;
		logic fbit;
		logic data;
	} bert_rxbit_t;

	// Generated bit handed to a formatter
	typedef struct packed {
		logic valid;
		logic data;
	} bert_txbit_t;

	// Pattern engine state
	typedef struct packed {
		logic [14:0] lfsr;
		logic [6:0]  prbs7;
		logic [5:0]  octet;
		logic [2:0]  bitno;
	} bert_gen_state_t;

	// Tester core state
	typedef struct packed {
		logic [7:0]  ctrl1;
		logic [7:0]  ifctrl;
		logic [7:0]  ratectrl;
		logic [9:0]  quota;
		logic [9:0]  left;
		logic [31:0] bit_cnt;
		logic [23:0] err_cnt;
		logic [31:0] run_bits;
		logic [23:0] run_errs;
		logic [17:0] rate_cnt;
		logic        cnt_load_prev;
		logic        quota_load_prev;
		logic        align_prev;
		logic [7:0]  rdata;
		bert_txbit_t line_tx;
		bert_txbit_t sys_rx;
	} bert_state_t;

endpackage : bert_pkg

// ### verilog/bert_regs.svh
`ifndef BERT_REGS_SVH
`define BERT_REGS_SVH

// Register offsets on the byte-wide host port
`define BERT_OFS_CTRL1     8'hE0
`define BERT_OFS_BITCNT0   8'hE3
`define BERT_OFS_BITCNT1   8'hE4
`define BERT_OFS_BITCNT2   8'hE5
`define BERT_OFS_BITCNT3   8'hE6
`define BERT_OFS_ERRCNT0   8'hE7
`define BERT_OFS_ERRCNT1   8'hE8
`define BERT_OFS_ERRCNT2   8'hE9
`define BERT_OFS_IFCTRL    8'hEA
`define BERT_OFS_RATECTRL  8'hEB
`define BERT_OFS_QUOTA_LO  8'hEC
`define BERT_OFS_QUOTA_HI  8'hED
`define BERT_OFS_LEFT_LO   8'hEE
`define BERT_OFS_LEFT_HI   8'hEF

// Field positions
`define BERT_CTRL1_CNT_LOAD 1
`define BERT_CTRL1_PS_LO   2
`define BERT_CTRL1_PS_HI   4
`define BERT_IC_EN         0
`define BERT_IC_DIR        1
`define BERT_IC_TX_UNFR    3
`define BERT_IC_ALIGN      4
`define BERT_IC_RX_UNFR    6
`define BERT_ERC_RATE_LO   0
`define BERT_ERC_RATE_HI   3
`define BERT_ERC_CE        4
`define BERT_ERC_QLOAD     7

// Reset values and writable masks
`define BERT_RST_BYTE      8'h00
`define BERT_MASK_CTRL1    8'h1E
`define BERT_MASK_IFCTRL   8'h5B
`define BERT_MASK_RATECTRL 8'h9F

// Pattern and insertion timing
`define BERT_RATE_SHIFT    5'h03
`define BERT_DALY_CODE     3'h6
`define BERT_DALY_LAST     6'h36
`define BERT_PRBS15_SEED   15'h7FFF
`define BERT_PRBS7_SEED    7'h7F

`endif

// ### verilog/bert_top.sv
// Function
// - 32-bit bit count over four byte registers
// - 24-bit error count over three byte registers
// - Receive F-bit reaches tester only when unframed
// - Tester drives transmit F-bit only when unframed
// - Byte-align rise realigns pattern to formatter bytes
// - Direction 0 sends to line, checks line
// - Direction 1 sends to system, checks system
// - Tester runs only while enable bit set
// - Load-number rise loads quota next cycle
// - Constant mode ignores quota, inserts at rate
// - Counted mode inserts only the loaded number
// - Rate code sets interval 16 to 262144
// - 10-bit error quota over two registers
// - Errors-left count readable at any time
// - Load-counters rise latches and clears counts
// - Code 110 gives byte-aligned 55-octet pattern
`timescale 1ns/100ps
`default_nettype none
`include "bert_regs.svh"

module bert_top (
	input  wire logic                   I_REF_CLK,
	input  wire logic                   I_ARST_N,
	input  wire logic [7:0]             I_ADDR,
	input  wire logic [7:0]             I_WDATA,
	input  wire logic                   I_WR,
	input  wire logic                   I_RD,
	output logic      [7:0]             O_RDATA,
	input  wire bert_pkg::bert_slot_t   I_LINE_TX_SLOT,
	input  wire bert_pkg::bert_slot_t   I_SYS_RX_SLOT,
	input  wire bert_pkg::bert_rxbit_t  I_LINE_RX,
	input  wire bert_pkg::bert_rxbit_t  I_SYS_TX,
	output bert_pkg::bert_txbit_t       O_LINE_TX,
	output bert_pkg::bert_txbit_t       O_SYS_RX
);

	bert_pkg::bert_state_t st;
	bert_pkg::bert_state_t next_st;

	logic                  en;
	logic                  dir;
	logic                  tx_unframed;
	logic                  rx_unframed;
	logic                  ce;
	logic [3:0]            rate;
	logic                  daly;
	logic                  cnt_load_rise;
	logic                  quota_load_rise;
	logic                  align_rise;
	bert_pkg::bert_slot_t  tx_slot;
	bert_pkg::bert_rxbit_t rx_src;
	logic                  tx_adv;
	logic                  rx_cmp;
	logic                  tx_bit;
	logic                  rx_exp;
	logic                  rx_err;
	logic [17:0]           rate_last;
	logic                  rate_due;
	logic                  insert;

	// Control field decode
	assign en   = st.ifctrl[`BERT_IC_EN];
	assign dir  = st.ifctrl[`BERT_IC_DIR];
	assign tx_unframed = st.ifctrl[`BERT_IC_TX_UNFR];
	assign rx_unframed = st.ifctrl[`BERT_IC_RX_UNFR];
	assign ce   = st.ratectrl[`BERT_ERC_CE];
	assign rate = st.ratectrl[`BERT_ERC_RATE_HI:`BERT_ERC_RATE_LO];
	assign daly = st.ctrl1[`BERT_CTRL1_PS_HI:`BERT_CTRL1_PS_LO]
		== `BERT_DALY_CODE;

	// Rising edges of the toggle bits, seen one cycle after the write
	assign cnt_load_rise = st.ctrl1[`BERT_CTRL1_CNT_LOAD]
		& ~st.cnt_load_prev;
	assign quota_load_rise = st.ratectrl[`BERT_ERC_QLOAD]
		& ~st.quota_load_prev;
	assign align_rise = st.ifctrl[`BERT_IC_ALIGN] & ~st.align_prev;

	// Direction picks which formatter feeds and which stream is checked
	assign tx_slot = dir ? I_SYS_RX_SLOT : I_LINE_TX_SLOT;
	assign rx_src  = dir ? I_SYS_TX : I_LINE_RX;

	// F-bit slots are skipped unless unframed operation is selected
	assign tx_adv = en & tx_slot.stb
		& (~tx_slot.fbit | tx_unframed);
	assign rx_cmp = en & rx_src.stb
		& (~rx_src.fbit | rx_unframed);

	// Transmit pattern engine, realigned on the byte-align toggle
	bert_patgen u_tx_gen (
		.i_clk        (I_REF_CLK),
		.i_arst_n     (I_ARST_N),
		.i_stb        (tx_adv),
		.i_realign    (align_rise),
		.i_byte_start (daly & tx_slot.byte_start),
		.i_daly       (daly),
		.i_selfsync   (1'b0),
		.i_in_bit     (1'b0),
		.o_bit        (tx_bit)
	);

	// Receive reference; PRBS self-syncs on the incoming bits
	bert_patgen u_rx_gen (
		.i_clk        (I_REF_CLK),
		.i_arst_n     (I_ARST_N),
		.i_stb        (rx_cmp),
		.i_realign    (cnt_load_rise),
		.i_byte_start (1'b0),
		.i_daly       (daly),
		.i_selfsync   (~daly),
		.i_in_bit     (rx_src.data),
		.o_bit        (rx_exp)
	);

	assign rx_err = rx_cmp & (rx_src.data ^ rx_exp);

	// Interval is 2^(code+3) bits; the 19-bit form keeps code 15 exact
	assign rate_last = 18'((19'h00001 << ({1'b0, rate} + `BERT_RATE_SHIFT))
		- 19'h00001);
	assign rate_due = tx_adv & (rate != 4'h0) & (st.rate_cnt == rate_last);
	assign insert = rate_due & (ce | (st.left != 10'h000));

	// Next-state logic: host port, insertion and counters
	always_comb begin
		next_st = st;
		next_st.cnt_load_prev   = st.ctrl1[`BERT_CTRL1_CNT_LOAD];
		next_st.quota_load_prev = st.ratectrl[`BERT_ERC_QLOAD];
		next_st.align_prev      = st.ifctrl[`BERT_IC_ALIGN];

		// Host writes; count registers are read-only and ignore writes
		if (I_WR) begin
			case (I_ADDR)
				`BERT_OFS_CTRL1:
					next_st.ctrl1 = I_WDATA & `BERT_MASK_CTRL1;
				`BERT_OFS_IFCTRL:
					next_st.ifctrl = I_WDATA & `BERT_MASK_IFCTRL;
				`BERT_OFS_RATECTRL:
					next_st.ratectrl = I_WDATA & `BERT_MASK_RATECTRL;
				`BERT_OFS_QUOTA_LO:
					next_st.quota[7:0] = I_WDATA;
				`BERT_OFS_QUOTA_HI:
					next_st.quota[9:8] = I_WDATA[1:0];
				default: begin
				end
			endcase
		end

		// Host reads are registered; unmapped addresses answer zero
		if (I_RD) begin
			case (I_ADDR)
				`BERT_OFS_CTRL1:    next_st.rdata = st.ctrl1;
				`BERT_OFS_BITCNT0:  next_st.rdata = st.bit_cnt[7:0];
				`BERT_OFS_BITCNT1:  next_st.rdata = st.bit_cnt[15:8];
				`BERT_OFS_BITCNT2:  next_st.rdata = st.bit_cnt[23:16];
				`BERT_OFS_BITCNT3:  next_st.rdata = st.bit_cnt[31:24];
				`BERT_OFS_ERRCNT0:  next_st.rdata = st.err_cnt[7:0];
				`BERT_OFS_ERRCNT1:  next_st.rdata = st.err_cnt[15:8];
				`BERT_OFS_ERRCNT2:  next_st.rdata = st.err_cnt[23:16];
				`BERT_OFS_IFCTRL:   next_st.rdata = st.ifctrl;
				`BERT_OFS_RATECTRL: next_st.rdata = st.ratectrl;
				`BERT_OFS_QUOTA_LO: next_st.rdata = st.quota[7:0];
				`BERT_OFS_QUOTA_HI: next_st.rdata = {6'h00, st.quota[9:8]};
				`BERT_OFS_LEFT_LO:  next_st.rdata = st.left[7:0];
				`BERT_OFS_LEFT_HI:  next_st.rdata = {6'h00, st.left[9:8]};
				default:            next_st.rdata = `BERT_RST_BYTE;
			endcase
		end

		// Rate divider runs on generated bits only
		if (tx_adv) begin
			next_st.rate_cnt = rate_due ? 18'h00000 : st.rate_cnt + 18'h00001;
		end
		if (!en || rate == 4'h0) begin
			next_st.rate_cnt = 18'h00000;
		end

		// Load of the quota wins over a same-cycle decrement
		if (quota_load_rise) begin
			next_st.left = st.quota;
		end else if (insert && !ce) begin
			next_st.left = st.left - 10'h001;
		end

		// Running counts; a latch keeps the bit arriving in that cycle
		if (cnt_load_rise) begin
			next_st.bit_cnt  = st.run_bits;
			next_st.err_cnt  = st.run_errs;
			next_st.run_bits = {31'h00000000, rx_cmp};
			next_st.run_errs = {23'h000000, rx_err};
		end else begin
			next_st.run_bits = st.run_bits + {31'h00000000, rx_cmp};
			next_st.run_errs = st.run_errs + {23'h000000, rx_err};
		end

		// Outgoing bits carry the pattern, inverted where an error goes in
		next_st.line_tx.valid = tx_adv & ~dir;
		next_st.sys_rx.valid  = tx_adv & dir;
		next_st.line_tx.data  = tx_adv & ~dir & (tx_bit ^ insert);
		next_st.sys_rx.data   = tx_adv & dir & (tx_bit ^ insert);
	end

	// State register
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign O_RDATA   = st.rdata;
	assign O_LINE_TX = st.line_tx;
	assign O_SYS_RX  = st.sys_rx;

	// Checks on the core state
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);

	// Latched bit count equals the running count before the latch
	AST_BITCNT_LATCH: assert property (
		cnt_load_rise |=> st.bit_cnt == $past(st.run_bits))
		else $error("bit count not latched from running count");

	// Latched error count equals the running error count
	AST_ERRCNT_LATCH: assert property (
		cnt_load_rise |=> st.err_cnt == $past(st.run_errs))
		else $error("error count not latched from running count");

	// Running count restarts from at most one bit after a latch
	AST_RUN_CLEARED: assert property (
		cnt_load_rise |=> st.run_bits <= 32'h00000001)
		else $error("running bit count not cleared");

	// Each compared bit adds exactly one to the running count
	AST_BIT_STEP: assert property (
		rx_cmp && !cnt_load_rise
		|=> st.run_bits == $past(st.run_bits) + 32'h1)
		else $error("bit count did not advance");

	// Framed receive never compares the F-bit
	AST_RX_FRAMED: assert property (
		rx_src.stb && rx_src.fbit && !rx_unframed |-> !rx_cmp)
		else $error("F-bit compared while framed");

	// Framed transmit never places tester data in the F-bit slot
	AST_TX_FRAMED: assert property (
		tx_slot.stb && tx_slot.fbit && !tx_unframed
		|=> !O_LINE_TX.valid && !O_SYS_RX.valid)
		else $error("tester drove F-bit while framed");

	// Disabled tester drives neither stream
	AST_DISABLED: assert property (
		!en |=> !O_LINE_TX.valid && !O_SYS_RX.valid)
		else $error("output valid while tester disabled");

	// System direction keeps the line transmitter free
	AST_DIR_SYSTEM: assert property (
		dir |=> !O_LINE_TX.valid)
		else $error("line output used in system direction");

	// Network direction keeps the system output free
	AST_DIR_NETWORK: assert property (
		!dir |=> !O_SYS_RX.valid)
		else $error("system output used in network direction");

	// Quota reaches the insertion logic one cycle after the rise
	AST_QUOTA_LOAD: assert property (
		quota_load_rise |=> st.left == $past(st.quota))
		else $error("quota not loaded after load bit rise");

	// Rate code zero never inserts
	AST_RATE_ZERO: assert property (
		rate == 4'h0 |-> !insert)
		else $error("error inserted with rate zero");

	// Insertion only at the end of the programmed interval
	AST_RATE_SPACING: assert property (
		insert |-> st.rate_cnt == rate_last)
		else $error("insertion off the rate interval");

	// Counted mode stops once nothing is left
	AST_COUNT_STOP: assert property (
		!ce && st.left == 10'h000 |-> !insert)
		else $error("error inserted with none left");

	// Counted insertion takes one from the left count
	AST_LEFT_DEC: assert property (
		insert && !ce && !quota_load_rise
		|=> st.left == $past(st.left) - 10'h1)
		else $error("left count not decremented");

	// Constant mode leaves the left count alone
	AST_CONST_HOLD: assert property (
		insert && ce && !quota_load_rise |=> st.left == $past(st.left))
		else $error("left count changed in constant mode");

	// Main scenarios
	COV_INSERT_COUNTED: cover property (insert && !ce ##1 st.left == 10'h0);
	COV_INSERT_CONST: cover property (insert && ce);
	COV_LATCH: cover property (rx_err ##[1:50] cnt_load_rise);
	COV_SYSTEM_DIR: cover property (dir && tx_adv);

endmodule : bert_top
`default_nettype wire
